/* hdl/erpm_counter.sv */
// wrapping event counter with load and clear
`timescale 1ns/1ps
module erpm_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             inc,
  input  wire logic             clr,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  // state
  output logic      [WIDTH-1:0] count
);

  // clear beats load beats increment; all-ones rolls to zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
    end
    else if (clr)
    begin
      count <= '0;
    end
    else if (load)
    begin
      count <= load_value;
    end
    else if (inc)
    begin
      count <= count + WIDTH'(1);
    end
  end

endmodule

/* hdl/erpm_pkg.sv */
// constants, register indices and carrier types of the receive monitor status bank
package erpm_pkg;

  // bus geometry
  localparam int ERPM_ADDR_W = 8;
  localparam int ERPM_DATA_W = 32;
  localparam int ERPM_IDX_W  = 6;

  // register indices, byte address is four times the index
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_PRBS_ERR  = 6'h10;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_PRBS_MF   = 6'h11;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_ALARM     = 6'h12;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_EFAS      = 6'h13;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_FEBE_HI   = 6'h14;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_FEBE_LO   = 6'h15;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_BPV_HI    = 6'h16;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_BPV_LO    = 6'h17;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_CRC_HI    = 6'h18;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_CRC_LO    = 6'h19;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_SYNC_EV   = 6'h1b;
  localparam logic [ERPM_IDX_W-1:0] ERPM_IDX_IRQ_MASK  = 6'h20;

  // values after reset
  localparam logic [7:0] ERPM_MASK_RESET = 8'hff;
  localparam logic [7:0] ERPM_FLAG_RESET = 8'h00;

  // counter widths
  localparam int ERPM_CNT8_W  = 8;
  localparam int ERPM_CNT10_W = 10;
  localparam int ERPM_CNT16_W = 16;

  // digital loss of signal: run of zero bits
  localparam logic [7:0] ERPM_LOS_ZERO_RUN = 8'hc0;

  // alarm event latch bit positions
  localparam int ERPM_AL_REMOTE = 7;
  localparam int ERPM_AL_ALLONE = 6;
  localparam int ERPM_AL_SLOT16 = 5;
  localparam int ERPM_AL_LOSS   = 4;
  localparam int ERPM_AL_AUXPAT = 3;
  localparam int ERPM_AL_MULTIFRAME_ALARM_FLAG  = 2;
  localparam int ERPM_AL_SLIP   = 1;

  // sync event word bit positions
  localparam int ERPM_IW_FRAME  = 7;
  localparam int ERPM_IW_MF     = 6;
  localparam int ERPM_IW_CRC    = 5;
  localparam int ERPM_IW_ALLONE = 4;
  localparam int ERPM_IW_LOSS   = 3;
  localparam int ERPM_IW_DBLFAS = 2;
  localparam int ERPM_IW_YLOSS  = 1;
  localparam int ERPM_IW_SLIP   = 0;

  // one-cycle event pulses from the receive framer
  typedef struct packed {
    logic prbs_error;
    logic crc_multiframe;
    logic fas_valid;
    logic fas_error;
    logic ebit_error;
    logic line_violation;
    logic crc4_error;
    logic buffer_slip;
  } erpm_rx_pulse_t;

  // condition levels from the receive framer
  typedef struct packed {
    logic remote_alarm;
    logic all_ones;
    logic slot16_all_ones;
    logic aux_pattern;
    logic mf_alarm;
    logic frame_sync;
    logic mf_sync;
    logic crc_sync;
    logic y_loss;
  } erpm_rx_level_t;

endpackage

/* hdl/erpm_status_bank.sv */
// receive performance monitor status bank with apb slave
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module erpm_status_bank
  import erpm_pkg::*;
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ERPM_ADDR_W-1:0] paddr,
  input  wire logic [ERPM_DATA_W-1:0] pwdata,
  output logic      [ERPM_DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  // receive framer events and conditions, same clock
  input  wire erpm_rx_pulse_t         rx_pulse,
  input  wire erpm_rx_level_t         rx_level,
  // decoded line bits, same clock
  input  wire logic                   line_bit_valid,
  input  wire logic                   line_bit,
  // analog low-level detect pin from the line interface
  input  wire logic                   analog_loss_pin,
  // live loss of signal level
  output logic                        signal_loss
);

  // bus phase decode
  logic                  setup_phase;
  logic                  access_done;
  logic                  wr_done;
  logic                  rd_done;
  logic [ERPM_IDX_W-1:0] idx;
  logic                  addr_ok;

  // counters
  logic [ERPM_CNT8_W-1:0]  pattern_error_tally;
  logic [ERPM_CNT8_W-1:0]  prbs_multiframe_count;
  logic [ERPM_CNT8_W-1:0]  errored_framing_count;
  logic [ERPM_CNT10_W-1:0] far_end_error_count;
  logic [ERPM_CNT16_W-1:0] line_violation_count;
  logic [ERPM_CNT10_W-1:0] checksum_error_total;

  // flag registers and mask
  logic [7:0] alarm_event_latch;
  logic [7:0] sync_event_flags;
  logic [7:0] irq_mask;
  logic [7:0] alarm_event;
  logic [7:0] sync_event;
  logic [7:0] alarm_clr;
  logic [7:0] sync_clr;

  // loss of signal detection
  logic       analog_meta;
  logic       analog_sync;
  logic [7:0] zero_run;
  logic       digital_loss;

  // condition history for change detection
  erpm_rx_level_t level_q;
  logic           last_fas_errored;

  // read mux result
  logic [7:0] next_rdata;
  logic       next_err;

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign wr_done     = access_done && pwrite;
  assign rd_done     = access_done && !pwrite;
  assign idx         = paddr[ERPM_ADDR_W-1:2];

  // only word-aligned known indices are mapped; 0x1a is a hole
  always_comb
  begin
    addr_ok = 1'b0;
    if (paddr[1:0] != 2'h0)
    begin
      addr_ok = 1'b0;
    end
    else if (idx >= ERPM_IDX_PRBS_ERR && idx <= ERPM_IDX_CRC_LO)
    begin
      addr_ok = 1'b1;
    end
    else if (idx == ERPM_IDX_SYNC_EV || idx == ERPM_IDX_IRQ_MASK)
    begin
      addr_ok = 1'b1;
    end
  end

  // read data selection; unused bits stay zero
  always_comb
  begin
    next_rdata = 8'h00;
    next_err   = !addr_ok;
    if (idx == ERPM_IDX_PRBS_ERR)
    begin
      next_rdata = pattern_error_tally;
    end
    else if (idx == ERPM_IDX_PRBS_MF)
    begin
      next_rdata = prbs_multiframe_count;
    end
    else if (idx == ERPM_IDX_ALARM)
    begin
      next_rdata = alarm_event_latch;
    end
    else if (idx == ERPM_IDX_EFAS)
    begin
      next_rdata = errored_framing_count;
    end
    else if (idx == ERPM_IDX_FEBE_HI)
    begin
      next_rdata = {6'h00, far_end_error_count[9:8]};
    end
    else if (idx == ERPM_IDX_FEBE_LO)
    begin
      next_rdata = far_end_error_count[7:0];
    end
    else if (idx == ERPM_IDX_BPV_HI)
    begin
      next_rdata = line_violation_count[15:8];
    end
    else if (idx == ERPM_IDX_BPV_LO)
    begin
      next_rdata = line_violation_count[7:0];
    end
    else if (idx == ERPM_IDX_CRC_HI)
    begin
      next_rdata = {6'h00, checksum_error_total[9:8]};
    end
    else if (idx == ERPM_IDX_CRC_LO)
    begin
      next_rdata = checksum_error_total[7:0];
    end
    else if (idx == ERPM_IDX_SYNC_EV)
    begin
      next_rdata = sync_event_flags;
    end
    else
    begin
      next_rdata = irq_mask;
    end
  end

  // no wait state: data sampled at setup, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata  <= {24'h000000, addr_ok ? next_rdata : 8'h00};
      pready  <= 1'b1;
      pslverr <= next_err;
    end
    else if (access_done)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // mask register; a one lets the event through
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask <= ERPM_MASK_RESET;
    end
    else if (wr_done && addr_ok && idx == ERPM_IDX_IRQ_MASK)
    begin
      irq_mask <= pwdata[7:0];
    end
  end

  // analog pin is asynchronous: two-flop synchroniser, then the registered loss level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      analog_meta <= 1'b0;
      analog_sync <= 1'b0;
      signal_loss <= 1'b0;
    end
    else
    begin
      analog_meta <= analog_loss_pin;
      analog_sync <= analog_meta;
      signal_loss <= analog_sync || digital_loss;
    end
  end

  // zero run length; any one restarts it, saturates at the threshold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zero_run <= 8'h00;
    end
    else if (line_bit_valid && line_bit)
    begin
      zero_run <= 8'h00;
    end
    else if (line_bit_valid && !digital_loss)
    begin
      zero_run <= zero_run + 8'h01;
    end
  end

  assign digital_loss = (zero_run == ERPM_LOS_ZERO_RUN);

  // framer history: last levels for two-way change detect, last alignment word state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_q          <= '0;
      last_fas_errored <= 1'b0;
    end
    else
    begin
      level_q <= rx_level;
      if (rx_pulse.fas_valid)
      begin
        last_fas_errored <= rx_pulse.fas_error;
      end
    end
  end

  // alarm latch set terms; levels keep re-setting while present
  always_comb
  begin
    alarm_event                 = 8'h00;
    alarm_event[ERPM_AL_REMOTE] = rx_level.remote_alarm;
    alarm_event[ERPM_AL_ALLONE] = rx_level.all_ones;
    alarm_event[ERPM_AL_SLOT16] = rx_level.slot16_all_ones;
    alarm_event[ERPM_AL_LOSS]   = digital_loss;
    alarm_event[ERPM_AL_AUXPAT] = rx_level.aux_pattern;
    alarm_event[ERPM_AL_MULTIFRAME_ALARM_FLAG]  = rx_level.mf_alarm;
    alarm_event[ERPM_AL_SLIP]   = rx_pulse.buffer_slip;
  end

  // sync event word set terms
  always_comb
  begin
    sync_event                 = 8'h00;
    sync_event[ERPM_IW_FRAME]  = rx_level.frame_sync ^ level_q.frame_sync;
    sync_event[ERPM_IW_MF]     = rx_level.mf_sync ^ level_q.mf_sync;
    sync_event[ERPM_IW_CRC]    = rx_level.crc_sync ^ level_q.crc_sync;
    sync_event[ERPM_IW_ALLONE] = rx_level.all_ones ^ level_q.all_ones;
    sync_event[ERPM_IW_LOSS]   = analog_sync || digital_loss;
    sync_event[ERPM_IW_DBLFAS] = rx_pulse.fas_valid && rx_pulse.fas_error
                                 && last_fas_errored;
    sync_event[ERPM_IW_YLOSS]  = rx_level.y_loss ^ level_q.y_loss;
    sync_event[ERPM_IW_SLIP]   = rx_pulse.buffer_slip;
  end

  // clear only what the host actually saw, so late events survive the read
  assign alarm_clr = (rd_done && addr_ok && idx == ERPM_IDX_ALARM) ? prdata[7:0] : 8'h00;
  assign sync_clr  = (rd_done && addr_ok && idx == ERPM_IDX_SYNC_EV) ? prdata[7:0] : 8'h00;

  // sticky flags, set beats clear; masked sync events are dropped, not kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_event_latch <= ERPM_FLAG_RESET;
      sync_event_flags  <= ERPM_FLAG_RESET;
    end
    else
    begin
      alarm_event_latch <= ((alarm_event_latch & ~alarm_clr) | alarm_event) & 8'hfe;
      sync_event_flags  <= (sync_event_flags & ~sync_clr) | (sync_event & irq_mask);
    end
  end

  // prbs error tally, host write loads it
  erpm_counter #(
    .WIDTH (ERPM_CNT8_W)
  ) u_prbs_err (
    .clk        (pclk),
    .rst_n      (presetn),
    .inc        (rx_pulse.prbs_error),
    .clr        (1'b0),
    .load       (wr_done && addr_ok && idx == ERPM_IDX_PRBS_ERR),
    .load_value (pwdata[7:0]),
    .count      (pattern_error_tally)
  );

  // multiframe companion; a write to the tally wins over a multiframe
  erpm_counter #(
    .WIDTH (ERPM_CNT8_W)
  ) u_prbs_mf (
    .clk        (pclk),
    .rst_n      (presetn),
    .inc        (rx_pulse.crc_multiframe),
    .clr        (wr_done && addr_ok && idx == ERPM_IDX_PRBS_ERR),
    .load       (1'b0),
    .load_value ('0),
    .count      (prbs_multiframe_count)
  );

  // read-only counters: no host write, wrap at all ones; split bytes are not
  // snapshotted, so a carry may land between the high and the low read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      errored_framing_count <= '0;
      far_end_error_count   <= '0;
      line_violation_count  <= '0;
      checksum_error_total  <= '0;
    end
    else
    begin
      if (rx_pulse.fas_valid && rx_pulse.fas_error)
      begin
        errored_framing_count <= errored_framing_count + 8'h01;
      end
      if (rx_pulse.ebit_error)
      begin
        far_end_error_count <= far_end_error_count + 10'h001;
      end
      if (rx_pulse.line_violation)
      begin
        line_violation_count <= line_violation_count + 16'h0001;
      end
      if (rx_pulse.crc4_error)
      begin
        checksum_error_total <= checksum_error_total + 10'h001;
      end
    end
  end

endmodule

/* sim/e1_rx_perf_monitor_status_bench.sv */
// self-checking bench for the receive monitor status bank
`timescale 1ns/1ps
module e1_rx_perf_monitor_status_bench
  import erpm_pkg::*;
;
  // clock, reset and apb
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [ERPM_ADDR_W-1:0] paddr = 8'h00;
  logic [ERPM_DATA_W-1:0] pwdata = 32'h0;
  logic [ERPM_DATA_W-1:0] prdata;
  logic                   pready;
  logic                   pslverr;
  // framer side
  erpm_rx_pulse_t         rx_pulse;
  erpm_rx_level_t         rx_level;
  logic                   lb_valid;
  logic                   lb;
  logic                   aloss;
  logic                   signal_loss;
  // bookkeeping
  int                     fails = 0;
  int                     n_checks = 0;
  int                     cyc = 0;
  logic [31:0]            rv;
  logic                   re;

  always #20 pclk = ~pclk;

  erpm_status_bank u_erpm_status_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pulse(rx_pulse), .rx_level(rx_level),
    .line_bit_valid(lb_valid), .line_bit(lb), .analog_loss_pin(aloss),
    .signal_loss(signal_loss)
  );

  erpm_framer u_erpm_framer (
    .clk(pclk), .rx_pulse(rx_pulse), .rx_level(rx_level),
    .bit_valid(lb_valid), .bit_val(lb), .analog_loss(aloss)
  );

  task automatic give_verdict();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle count assumed; pready ends this wait, the hang guard a stuck one
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rv, x);
  endtask

  task automatic t_reset();
    logic [7:0] a;
    // every mapped register starts empty, the mask fully open
    for (a = 8'h40; a < 8'h70; a = a + 8'h04)
      if (a != 8'h68)
        rdc(a, 32'h0);
    rdc(8'h80, 32'hff);
    // a hole and a misaligned address are refused with empty data
    rdc(8'h68, 32'h0);
    chk({31'h0, re}, 32'h1);
    apb(1'b0, 8'h41, 32'h0);
    chk({31'h0, re}, 32'h1);
    // a read-only counter ignores a write
    apb(1'b1, 8'h4c, 32'hff);
    rdc(8'h4c, 32'h0);
  endtask

  task automatic t_counts();
    u_erpm_framer.send(8'h80, 3);
    u_erpm_framer.send(8'h40, 2);
    rdc(8'h40, 32'h3);
    rdc(8'h44, 32'h2);
    // a write loads the low byte and empties the multiframe count
    apb(1'b1, 8'h40, 32'h1a5);
    rdc(8'h40, 32'ha5);
    rdc(8'h44, 32'h0);
    // 257 errored words wrap to one; clean words must not count
    u_erpm_framer.send(8'h30, 257);
    u_erpm_framer.send(8'h20, 3);
    rdc(8'h4c, 32'h1);
    // e-bit, violation and crc-4 run together first, then drop out one by one, e-bit first
    u_erpm_framer.send(8'h0e, 291);
    u_erpm_framer.send(8'h06, 220);
    u_erpm_framer.send(8'h02, 516);
    rdc(8'h50, 32'h1);
    rdc(8'h54, 32'h23);
    rdc(8'h58, 32'h1);
    rdc(8'h5c, 32'hff);
    rdc(8'h60, 32'h0);
    rdc(8'h64, 32'h3);
  endtask

  task automatic t_alarm();
    // all alarm levels up, one slip, then a long zero run
    u_erpm_framer.toggle(9'h1f0);
    u_erpm_framer.send(8'h01, 1);
    u_erpm_framer.bits(1'b0, 200);
    chk({31'h0, signal_loss}, 32'h1);
    // conditions gone; a single one ends the loss, flags must still hold
    u_erpm_framer.toggle(9'h1f0);
    u_erpm_framer.bits(1'b1, 1);
    repeat (4) @(posedge pclk);
    chk({31'h0, signal_loss}, 32'h0);
    rdc(8'h48, 32'hfe);
    rdc(8'h48, 32'h0);
  endtask

  task automatic t_sync();
    int i;
    // drop leftovers from earlier traffic
    apb(1'b0, 8'h6c, 32'h0);
    for (i = 7; i >= 0; i--)
    begin
      case (i)
        7: u_erpm_framer.toggle(9'h008);
        6: u_erpm_framer.toggle(9'h004);
        5: u_erpm_framer.toggle(9'h002);
        4: u_erpm_framer.toggle(9'h080);
        3: u_erpm_framer.blip(8);
        2: u_erpm_framer.send(8'h30, 2);
        1: u_erpm_framer.toggle(9'h001);
        default: u_erpm_framer.send(8'h01, 1);
      endcase
      repeat (8) @(posedge pclk);
      rdc(8'h6c, 32'h1 << i);
      rdc(8'h6c, 32'h0);
    end
    // a masked event is dropped, not kept for later
    apb(1'b1, 8'h80, 32'h7f);
    u_erpm_framer.toggle(9'h008);
    repeat (4) @(posedge pclk);
    apb(1'b1, 8'h80, 32'hff);
    rdc(8'h6c, 32'h0);
    rdc(8'h80, 32'hff);
  endtask

  // hang guard, well above the roughly 1800 cycles the run needs
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  // reset, then the scenarios in turn
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_counts();
    t_alarm();
    t_sync();
    give_verdict();
  end
endmodule

/* sim/erpm_framer.sv */
// receive framer stand-in: event pulses, condition levels, line bits, analog pin
`timescale 1ns/1ps
module erpm_framer
  import erpm_pkg::*;
(
  // clock
  input  wire logic     clk,
  // framer outputs
  output erpm_rx_pulse_t rx_pulse,
  output erpm_rx_level_t rx_level,
  output logic           bit_valid,
  output logic           bit_val,
  output logic           analog_loss
);
  // quiet line at time zero
  initial
  begin
    rx_pulse = '0;
    rx_level = '0;
    bit_valid = 1'b0;
    bit_val = 1'b1;
    analog_loss = 1'b0;
  end

  // pulse pattern held n back-to-back cycles, one count per cycle
  task automatic send(input erpm_rx_pulse_t p, input int n);
    @(posedge clk);
    rx_pulse <= p;
    repeat (n) @(posedge clk);
    rx_pulse <= '0;
  endtask

  // n decoded bits of one value; the idle line shows the inverse, never a stale bit
  task automatic bits(input logic b, input int n);
    @(posedge clk);
    bit_valid <= 1'b1;
    bit_val <= b;
    repeat (n) @(posedge clk);
    bit_valid <= 1'b0;
    bit_val <= ~b;
  endtask

  // flip the selected condition levels
  task automatic toggle(input erpm_rx_level_t m);
    @(posedge clk);
    rx_level <= rx_level ^ m;
  endtask

  // analog low-level burst of n cycles
  task automatic blip(input int n);
    @(posedge clk);
    analog_loss <= 1'b1;
    repeat (n) @(posedge clk);
    analog_loss <= 1'b0;
  endtask
endmodule

/* sim/erpm_status_bank_properties.sv */
// port-level assertions for the receive monitor status bank
`timescale 1ns/1ps
module erpm_status_bank_properties
  import erpm_pkg::*;
(
  // clock and reset
  input wire logic                   pclk,
  input wire logic                   presetn,
  // apb slave
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [ERPM_ADDR_W-1:0] paddr,
  input wire logic [ERPM_DATA_W-1:0] pwdata,
  input wire logic [ERPM_DATA_W-1:0] prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // framer side
  input wire erpm_rx_pulse_t         rx_pulse,
  input wire erpm_rx_level_t         rx_level,
  input wire logic                   line_bit_valid,
  input wire logic                   line_bit,
  input wire logic                   analog_loss_pin,
  input wire logic                   signal_loss
);
  logic [7:0] zrun;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // zero run on the line, saturating so a long run never wraps under the limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      zrun <= 8'h00;
    else if (line_bit_valid)
      zrun <= line_bit ? 8'h00 : zrun + {7'h00, zrun != 8'hff};
  end

  // apb phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  a_ready_next: assert property (s_setup |=> pready)
    else $error("pready missing in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past completion");
  a_err_refused: assert property (s_setup ##0 (paddr[1:0] != 2'b00 || paddr == 8'h68)
    |=> pslverr) else $error("bad address not refused");
  a_err_no_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_alarm_bit0: assert property (s_rd(8'h48) |=> !prdata[0])
    else $error("alarm latch bit 0 set");
  a_febe_hi_zero: assert property (s_rd(8'h50) |=> prdata[7:2] == 6'h00)
    else $error("e-bit high byte unused bits set");
  a_crc_hi_zero: assert property (s_rd(8'h60) |=> prdata[7:2] == 6'h00)
    else $error("crc-4 high byte unused bits set");
  a_loss_analog: assert property (analog_loss_pin [*5] |-> signal_loss)
    else $error("analog loss not reported");
  a_loss_zero_run: assert property (zrun >= 8'hc1 |-> signal_loss)
    else $error("zero run loss not reported");
endmodule

bind erpm_status_bank erpm_status_bank_properties u_erpm_status_bank_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_pulse(rx_pulse), .rx_level(rx_level),
  .line_bit_valid(line_bit_valid), .line_bit(line_bit),
  .analog_loss_pin(analog_loss_pin), .signal_loss(signal_loss)
);
